/* File: tb/tb.sv */
// testbench: routing, qualifier modes, latency register and monitor fifo
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                          i_mclk = 1'b0;
    logic                          i_resetn = 1'b0;
    logic                          psel = 1'b0;
    logic                          penable = 1'b0;
    logic                          pwrite = 1'b0;
    logic [7:0]                    paddr = 8'h00;
    logic [31:0]                   pwdata = 32'h0;
    logic                          pready, pslverr, clk_ab, clk_cd, busy;
    logic [31:0]                   prdata, rdv;
    logic                          erv;
    wafe_pkg::wafe_sample_s [3:0]  port_sample, exp_d;
    wafe_pkg::wafe_sample_s [3:0]  data = '0;
    logic [3:0]                    port_qual;
    logic [3:0]                    qual = 4'h0;
    logic [1:0]                    clk_en = 2'h0;
    logic                          go = 1'b0;
    wafe_pkg::wafe_sample_s [7:0]  chan_sample;
    logic [7:0]                    chan_accept, chan_compute, acc, cmp;
    logic                          mon_valid, mon_in_ready;
    logic                          mon_ready = 1'b0;
    wafe_pkg::wafe_mon_s           mon_data;
    int                            error_cnt = 0;
    int                            comparisons = 0;
    int                            seqn = 1;

    always #12.5 i_mclk = ~i_mclk;

    wafe_adc_model u_adc (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_go(go), .i_clk_en(clk_en),
        .i_data(data), .i_qual(qual), .o_clock_ports_ab(clk_ab), .o_clock_ports_cd(clk_cd),
        .o_port_sample(port_sample), .o_port_qual(port_qual), .o_busy(busy));

    wafe_front_end i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_prdata(prdata), .i_clock_ports_ab(clk_ab), .i_clock_ports_cd(clk_cd),
        .i_port_sample(port_sample), .i_port_sample_qualifier(port_qual), .o_chan_sample(chan_sample),
        .o_chan_accept(chan_accept), .o_chan_compute(chan_compute), .o_mon_valid(mon_valid),
        .i_mon_ready(mon_ready), .o_mon_data(mon_data), .o_mon_in_ready(mon_in_ready));

    task automatic conclude();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            conclude();
        end
    endtask

    // one port clock period; pulses are or-ed over the frame
    task automatic tick(input logic [1:0] en, input logic [3:0] q);
        int n;
        for (int p = 0; p < 4; p++) begin
            exp_d[p] = {14'(seqn * 4 + p) ^ 14'h2000, 3'(p)};
        end
        seqn++;
        @(posedge i_mclk);
        data   <= exp_d;
        clk_en <= en;
        qual   <= q;
        go     <= 1'b1;
        @(posedge i_mclk);
        go  <= 1'b0;
        acc = 8'h00;
        cmp = 8'h00;
        repeat (6) begin
            @(negedge i_mclk);
            acc |= chan_accept;
            cmp |= chan_compute;
        end
        n = 0;
        while (busy && n < 10) begin
            @(negedge i_mclk);
            n++;
        end
        if (busy) begin
            error_cnt++;
            conclude();
        end
    endtask

    // new config becomes active at the following port clock
    task automatic cfg(input logic [31:0] w);
        apb(1'b1, wafe_pkg::ADDR_CHAN_CFG, w);
        tick(2'h3, 4'h0);
    endtask

    task automatic t_regs();
        apb(1'b0, wafe_pkg::ADDR_CHAN_CFG, 32'h0);
        check("chan_cfg", rdv, wafe_pkg::CHAN_CFG_RST);
        apb(1'b0, wafe_pkg::ADDR_LATENCY, 32'h0);
        check("latency_rst", rdv, 32'(1 * (1 + 7) + 1 + 26));
        apb(1'b1, wafe_pkg::ADDR_LAT_CFG, 32'hffffffff);
        apb(1'b0, wafe_pkg::ADDR_LATENCY, 32'h0);
        check("latency_max", rdv, 32'(255 * (255 + 7) + 255 + 26));
        apb(1'b1, wafe_pkg::ADDR_LAT_CFG, 32'h00400503);
        apb(1'b0, wafe_pkg::ADDR_LATENCY, 32'h0);
        check("latency", rdv, 32'(3 * (5 + 7) + 64 + 26));
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", {rdv[30:0], erv}, 32'h1);
        apb(1'b1, wafe_pkg::ADDR_MON_CFG, 32'h0);
    endtask

    task automatic t_fifo();
        wafe_pkg::wafe_sample_s q[$];
        for (int i = 0; i < 9; i++) begin
            tick(2'h3, 4'hf);
            if (i < 8) q.push_back(exp_d[0]);
        end
        check("mon_in_ready", 32'(mon_in_ready), 32'h0);
        apb(1'b0, wafe_pkg::ADDR_STATUS, 32'h0);
        check("status", rdv & 32'h0f01, 32'h0801);
        mon_ready <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge i_mclk);
            check("mon_data", {mon_valid, mon_data}, {1'b1, 3'h0, q[i]});
        end
        @(posedge i_mclk);
        mon_ready <= 1'b0;
        @(negedge i_mclk);
        check("mon_empty", 32'(mon_valid), 32'h0);
        apb(1'b1, wafe_pkg::ADDR_STATUS, 32'h1);
        apb(1'b0, wafe_pkg::ADDR_STATUS, 32'h0);
        check("ovf_clear", rdv & 32'h0f01, 32'h0);
    endtask

    task automatic t_route();
        wafe_pkg::wafe_sample_s s;
        cfg(32'h54545454);
        tick(2'h3, 4'hf);
        check("accept_all", acc, 32'hff);
        for (int c = 0; c < 4; c++) begin
            check("chan_lo", chan_sample[c], exp_d[c % 2]);
        end
        for (int c = 4; c < 8; c++) begin
            check("chan_hi", chan_sample[c], exp_d[2 + c % 2]);
        end
        check("fmt", chan_sample[1], {14'(seqn * 4 - 3) ^ 14'h2000, 3'h1});
        s = chan_sample[4];
        tick(2'h1, 4'hf);
        check("clock_ab", {acc, cmp}, 32'h0f0f);
        check("hold_cd", chan_sample[4], s);
    endtask

    task automatic t_level();
        wafe_pkg::wafe_sample_s s;
        s = chan_sample[1];
        tick(2'h3, 4'h5);
        check("level_acc", acc, 32'h55);
        check("level_hold", chan_sample[1], s);
        check("compute", cmp, 32'hff);
    endtask

    task automatic t_blank();
        cfg(32'h76767676);
        tick(2'h3, 4'h3);
        check("blank_acc", acc, 32'hff);
        check("blank_pass", chan_sample[1], exp_d[1]);
        check("blank_zero_c", chan_sample[4], 32'h0);
        check("blank_zero_d", chan_sample[5], 32'h0);
    endtask

    task automatic t_trans();
        logic [5:0] qs = 6'b011001;
        logic [5:0] fe = 6'b100010;
        logic [5:0] re = 6'b001001;
        wafe_pkg::wafe_sample_s s;
        cfg(32'h44444420);
        for (int i = 0; i < 6; i++) begin
            tick(2'h1, {3'h0, qs[i]});
            check("fall", acc[0], fe[i]);
            check("rise", acc[1], re[i]);
            check("compute", cmp[0], 32'h1);
            if (i == 3) s = exp_d[0];
        end
        check("rise_hold", chan_sample[1], s);
        check("interleave", chan_sample[0], exp_d[0]);
    endtask

    initial begin
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_regs();
        t_fifo();
        t_route();
        t_level();
        t_blank();
        t_trans();
        conclude();
    end
endmodule
`default_nettype wire

/* File: tb/wafe_adc_model.sv */
// partner model: four adc ports and their two port clocks
`timescale 1ns/1ps
`default_nettype none
module wafe_adc_model (
    // clock and reset
    input  wire logic                         i_mclk,
    input  wire logic                         i_resetn,
    // bench control
    input  wire logic                         i_go,
    input  wire logic [1:0]                   i_clk_en,
    input  wire wafe_pkg::wafe_sample_s [3:0] i_data,
    input  wire logic [3:0]                   i_qual,
    // adc pins
    output logic                              o_clock_ports_ab,
    output logic                              o_clock_ports_cd,
    output wafe_pkg::wafe_sample_s [3:0]      o_port_sample,
    output logic [3:0]                        o_port_qual,
    output logic                              o_busy
);
    logic [1:0] phase;
    logic [1:0] en;

    // port clocks stand low between frames
    assign o_clock_ports_ab = en[0] & (phase == 2'h1 || phase == 2'h2);
    assign o_clock_ports_cd = en[1] & (phase == 2'h1 || phase == 2'h2);
    assign o_busy           = (phase != 2'h0);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase <= 2'h0;
            en    <= 2'h0;
        end else if (i_go && phase == 2'h0) begin
            phase <= 2'h1;
            en    <= i_clk_en;
        end else if (phase != 2'h0) begin
            phase <= phase + 2'h1;
        end
    end

    // port A data may carry a zero exponent, as a fixed-point converter would
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_sample <= '0;
            o_port_qual   <= 4'h0;
        end else if (i_go && phase == 2'h0) begin
            o_port_sample <= i_data;
            o_port_qual   <= i_qual;
        end else if (phase == 2'h2) begin
            // hold time over: no stale value left on the lines
            o_port_sample <= ~o_port_sample;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/wafe_front_end.sv */
// design: fifo and the wideband adc input front end top
`timescale 1ns/1ps
`default_nettype none

module wafe_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data,
    // fill level
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("wafe_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign o_level     = wr_ptr - rd_ptr;
    assign o_in_ready  = (o_level != DEPTH[AW:0]);
    assign o_out_valid = (o_level != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // storage needs no reset; valid flags guard reads
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end
endmodule

module wafe_front_end #(
    parameter int NUM_CHANS = wafe_pkg::NUM_CHANS
) (
    // clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_resetn,
    // apb slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [7:0]            i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    output logic [31:0]                o_prdata,
    // adc input ports A to D
    input  wire logic                  i_clock_ports_ab,
    input  wire logic                  i_clock_ports_cd,
    input  wire wafe_pkg::wafe_sample_s [3:0] i_port_sample,
    input  wire logic [3:0]            i_port_sample_qualifier,
    // per-channel sample outputs
    output wafe_pkg::wafe_sample_s [7:0] o_chan_sample,
    output logic [7:0]                 o_chan_accept,
    output logic [7:0]                 o_chan_compute,
    // monitor stream
    output logic                       o_mon_valid,
    input  wire logic                  i_mon_ready,
    output wafe_pkg::wafe_mon_s        o_mon_data,
    output logic                       o_mon_in_ready
);
    initial begin
        if (NUM_CHANS != wafe_pkg::NUM_CHANS) begin
            $error("wafe_front_end serves exactly eight channels");
        end
    end

    localparam int LW = $clog2(wafe_pkg::FIFO_DEPTH);

    logic [31:0]         chan_cfg;
    logic [31:0]         lat_cfg;
    logic [31:0]         latency;
    logic [2:0]          mon_chan;
    logic                overflow;
    logic [31:0]         next_latency;
    logic                clk_ab_prev;
    logic                clk_cd_prev;
    logic                tick_ab;
    logic                tick_cd;
    logic [3:0]          qual_prev;
    logic [3:0]          port_tick;
    logic [3:0]          act_cfg [8];
    logic [1:0]          src_idx [8];
    logic [7:0]          chan_tick;
    logic [7:0]          acc_c;
    logic [7:0]          zero_c;
    wafe_pkg::wafe_sample_s src_sample [8];
    wafe_pkg::wafe_mon_s mon_in;
    logic                mon_push;
    logic [LW:0]         mon_level;
    logic                wr_en;
    logic                rd_en;

    // apb: zero-wait slave
    assign o_pready = 1'b1;
    assign wr_en    = i_psel && i_penable && i_pwrite;
    assign rd_en    = i_psel && !i_pwrite;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            chan_cfg <= wafe_pkg::CHAN_CFG_RST;
        end else if (wr_en && i_paddr == wafe_pkg::ADDR_CHAN_CFG) begin
            chan_cfg <= i_pwdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            lat_cfg <= wafe_pkg::LAT_CFG_RST;
        end else if (wr_en && i_paddr == wafe_pkg::ADDR_LAT_CFG) begin
            lat_cfg <= {8'h00, i_pwdata[23:0]};
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mon_chan <= 3'h0;
        end else if (wr_en && i_paddr == wafe_pkg::ADDR_MON_CFG) begin
            mon_chan <= i_pwdata[2:0];
        end
    end

    // overflow sticky, write one to clear; a new loss wins over the clear
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            overflow <= 1'b0;
        end else if (mon_push && !o_mon_in_ready) begin
            overflow <= 1'b1;
        end else if (wr_en && i_paddr == wafe_pkg::ADDR_STATUS && i_pwdata[wafe_pkg::ST_OVF_BIT]) begin
            overflow <= 1'b0;
        end
    end

    always_comb begin
        o_pslverr = 1'b0;
        o_prdata  = 32'h00000000;
        unique case (i_paddr)
            wafe_pkg::ADDR_CHAN_CFG: o_prdata = chan_cfg;
            wafe_pkg::ADDR_LAT_CFG:  o_prdata = lat_cfg;
            wafe_pkg::ADDR_LATENCY:  o_prdata = latency;
            wafe_pkg::ADDR_MON_CFG:  o_prdata = {29'h00000000, mon_chan};
            wafe_pkg::ADDR_STATUS: begin
                o_prdata[wafe_pkg::ST_OVF_BIT] = overflow;
                o_prdata[wafe_pkg::ST_LEVEL_LSB +: LW+1] = mon_level;
            end
            default:                 o_pslverr = i_psel && i_penable;
        endcase
        if (!rd_en) begin
            o_prdata = 32'h00000000;
        end
    end

    // end-to-end latency in fast clock cycles
    always_comb begin
        logic [7:0]  mr;
        logic [16:0] mc7;
        logic [17:0] prod;
        mr   = lat_cfg[wafe_pkg::LAT_MR_LSB +: wafe_pkg::LAT_FIELD_W];
        mc7  = {9'h000, lat_cfg[wafe_pkg::LAT_MC_LSB +: wafe_pkg::LAT_FIELD_W]} + wafe_pkg::LAT_CIC_ADD;
        prod = 18'(mr * mc7);
        next_latency = {14'h0000, 18'(prod + {10'h000, lat_cfg[wafe_pkg::LAT_TAPS_LSB +: wafe_pkg::LAT_FIELD_W]}
                        + wafe_pkg::LAT_FIXED_ADD)};
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            latency <= 32'h00000000;
        end else begin
            latency <= next_latency;
        end
    end

    // port clocks arrive synchronous to i_mclk; their rising edges become enables
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            clk_ab_prev <= 1'b0;
            clk_cd_prev <= 1'b0;
        end else begin
            clk_ab_prev <= i_clock_ports_ab;
            clk_cd_prev <= i_clock_ports_cd;
        end
    end

    assign tick_ab   = i_clock_ports_ab && !clk_ab_prev;
    assign tick_cd   = i_clock_ports_cd && !clk_cd_prev;
    assign port_tick = {tick_cd, tick_cd, tick_ab, tick_ab};

    // qualifier history kept per port at its own port clock
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            qual_prev <= 4'h0;
        end else begin
            for (int p = 0; p < wafe_pkg::NUM_PORTS; p++) begin
                if (port_tick[p]) begin
                    qual_prev[p] <= i_port_sample_qualifier[p];
                end
            end
        end
    end

    for (genvar c = 0; c < 8; c++) begin : g_chan
        wafe_pkg::wafe_mode_e mode;
        logic                 cur_q;
        logic                 old_q;

        assign chan_tick[c]  = (c < 4) ? tick_ab : tick_cd;
        // lower half reaches A/B only, upper half C/D only
        assign src_idx[c]    = {(c >= 4) ? 1'b1 : 1'b0, act_cfg[c][wafe_pkg::CFG_SEL_BIT]};
        assign src_sample[c] = i_port_sample[src_idx[c]];
        assign mode          = wafe_pkg::wafe_mode_e'(act_cfg[c][wafe_pkg::CFG_MODE_LSB +: 2]);
        assign cur_q         = i_port_sample_qualifier[src_idx[c]];
        assign old_q         = qual_prev[src_idx[c]];

        always_comb begin
            zero_c[c] = 1'b0;
            acc_c[c]  = 1'b0;
            unique case (mode)
                wafe_pkg::WAFE_MODE_FALL:  acc_c[c] = old_q && !cur_q;
                wafe_pkg::WAFE_MODE_RISE:  acc_c[c] = !old_q && cur_q;
                wafe_pkg::WAFE_MODE_HIGH:  acc_c[c] = cur_q;
                wafe_pkg::WAFE_MODE_BLANK: begin
                    acc_c[c]  = 1'b1;
                    zero_c[c] = !cur_q;
                end
            endcase
        end

        // new selection and mode applied only at the channel's next port clock
        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                act_cfg[c] <= wafe_pkg::CHAN_CFG_RST[c*4 +: 4];
            end else if (chan_tick[c]) begin
                act_cfg[c] <= chan_cfg[c*wafe_pkg::CFG_FIELD_W +: wafe_pkg::CFG_FIELD_W];
            end
        end

        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                o_chan_sample[c] <= '0;
            end else if (chan_tick[c] && acc_c[c]) begin
                o_chan_sample[c] <= zero_c[c] ? '0 : src_sample[c];
            end
        end

        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                o_chan_accept[c]  <= 1'b0;
                o_chan_compute[c] <= 1'b0;
            end else begin
                o_chan_accept[c]  <= chan_tick[c] && acc_c[c];
                o_chan_compute[c] <= chan_tick[c];
            end
        end
    end

    // monitor: accepted samples of one chosen channel; a full fifo drops and flags
    assign mon_push      = o_chan_accept[mon_chan];
    assign mon_in.chan   = mon_chan;
    assign mon_in.sample = o_chan_sample[mon_chan];

    wafe_fifo #(
        .WIDTH ($bits(wafe_pkg::wafe_mon_s)),
        .DEPTH (wafe_pkg::FIFO_DEPTH)
    ) u_mon_fifo (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_in_valid  (mon_push),
        .o_in_ready  (o_mon_in_ready),
        .i_in_data   (mon_in),
        .o_out_valid (o_mon_valid),
        .i_out_ready (i_mon_ready),
        .o_out_data  (o_mon_data),
        .o_level     (mon_level)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    sequence seq_fall_seen;
        tick_ab && act_cfg[0][2:1] == 2'h0 && qual_prev[src_idx[0]] && !i_port_sample_qualifier[src_idx[0]];
    endsequence

    sequence seq_rise_seen;
        tick_ab && act_cfg[0][2:1] == 2'h1 && !qual_prev[src_idx[0]] && i_port_sample_qualifier[src_idx[0]];
    endsequence

    chk_lower_source: assert property (
        o_chan_accept[0] && !$past(zero_c[0]) |-> o_chan_sample[0] == $past(src_sample[0]) && !$past(src_idx[0][1]))
        else $error("lower channel took a sample from a wrong port");
    chk_upper_source: assert property (
        o_chan_accept[4] && !$past(zero_c[4]) |-> o_chan_sample[4] == $past(src_sample[4]) && $past(src_idx[4][1]))
        else $error("upper channel took a sample from a wrong port");
    chk_port_clocking: assert property (
        (o_chan_accept[0] |-> $past(tick_ab)) and (o_chan_accept[4] |-> $past(tick_cd)))
        else $error("channel accepted without its port clock edge");
    chk_level_accept: assert property (
        tick_ab && act_cfg[0][2:1] == 2'h2 |=> o_chan_accept[0] == $past(i_port_sample_qualifier[src_idx[0]]))
        else $error("level mode accept does not follow qualifier");
    chk_fall_accept: assert property (
        seq_fall_seen |=> o_chan_accept[0])
        else $error("falling transition not accepted");
    chk_rise_accept: assert property (
        seq_rise_seen |=> o_chan_accept[0])
        else $error("rising transition not accepted");
    // qualifier must have moved, and now stand at the level the mode waits for
    chk_trans_only: assert property (
        o_chan_accept[0] && $past(act_cfg[0][2]) == 1'b0
        |-> $past(tick_ab && (qual_prev[src_idx[0]] != i_port_sample_qualifier[src_idx[0]])
                  && (i_port_sample_qualifier[src_idx[0]] == act_cfg[0][1])))
        else $error("transition mode accepted a non-qualifying edge");
    chk_blank_zero: assert property (
        tick_ab && act_cfg[0][2:1] == 2'h3 && !i_port_sample_qualifier[src_idx[0]]
        |=> o_chan_accept[0] && o_chan_sample[0] == '0)
        else $error("blank mode did not substitute zero");
    chk_compute_step: assert property (
        tick_ab |=> o_chan_compute[3:0] == 4'hf ##1 o_chan_compute[3:0] == 4'h0)
        else $error("computation step missing on port clock edge");
    chk_cfg_apply: assert property (
        (tick_cd |=> act_cfg[4] == $past(chan_cfg[19:16])) and (!tick_cd |=> $stable(act_cfg[4])))
        else $error("channel config not applied at its port clock");
    chk_latency_val: assert property (
        // latency resets to zero, so the first cycle after reset is not judged
        $stable(lat_cfg) [*2] ##0 $past(i_resetn)
        |-> latency == 32'(lat_cfg[7:0] * (lat_cfg[15:8] + 32'd7) + lat_cfg[23:16] + 32'd26))
        else $error("latency value does not match the filter settings");
endmodule

`default_nettype wire

/* File: verilog/wafe_pkg.sv */
// package: constants, register map and carrier types of the wideband adc input front end
// Function
// - channels 0 to 3 each pick port A or port B on their own
// - channels 4 to 7 each pick port C or port D on their own
// - each port carries a 14-bit two's complement mantissa and 3-bit unsigned exponent
// - a port sample is captured on its port clock's rising edge, which steps its channels
// - ports A and B follow the first port clock, ports C and D the second
// - each port has a qualifier; modes are falling, rising, level high, blank on low
// - level-high mode accepts samples only while the qualifier is high
// - falling mode accepts on the first port clock edge after qualifier goes low
// - rising mode accepts on the port clock edge after qualifier goes high
// - blank mode replaces the sample with zero whenever the qualifier is low
// - transition modes accept only the qualifying edge and ignore all others
// - every port clock edge still yields a new computation step downstream
// - latency equals resampling decimation times (integrator decimation plus 7) plus taps plus 26
// - interleaved data: one channel falling, another rising, qualifier from converter select
package wafe_pkg;
    localparam int          NUM_PORTS      = 4;
    localparam int          NUM_CHANS      = 8;
    localparam int          MANT_W         = 14;
    localparam int          EXP_W          = 3;
    localparam int          FIFO_DEPTH     = 8;
    // apb byte offsets
    localparam logic [7:0]  ADDR_CHAN_CFG  = 8'h00;
    localparam logic [7:0]  ADDR_LAT_CFG   = 8'h04;
    localparam logic [7:0]  ADDR_LATENCY   = 8'h08;
    localparam logic [7:0]  ADDR_MON_CFG   = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;
    // channel config: 4 bits per channel, bit0 port pick, bits 2:1 mode
    localparam int          CFG_FIELD_W    = 4;
    localparam int          CFG_SEL_BIT    = 0;
    localparam int          CFG_MODE_LSB   = 1;
    localparam logic [31:0] CHAN_CFG_RST   = 32'h44444444;
    // latency config fields
    localparam int          LAT_MR_LSB     = 0;
    localparam int          LAT_MC_LSB     = 8;
    localparam int          LAT_TAPS_LSB   = 16;
    localparam int          LAT_FIELD_W    = 8;
    localparam logic [31:0] LAT_CFG_RST    = 32'h00010101;
    localparam logic [16:0] LAT_CIC_ADD    = 17'h00007;
    localparam logic [17:0] LAT_FIXED_ADD  = 18'h0001a;
    // status fields
    localparam int          ST_OVF_BIT     = 0;
    localparam int          ST_LEVEL_LSB   = 8;

    typedef enum logic [1:0] {
        WAFE_MODE_FALL  = 2'h0,
        WAFE_MODE_RISE  = 2'h1,
        WAFE_MODE_HIGH  = 2'h2,
        WAFE_MODE_BLANK = 2'h3
    } wafe_mode_e;

    typedef struct packed {
        logic signed [MANT_W-1:0] mant;
        logic        [EXP_W-1:0]  expo;
    } wafe_sample_s;

    typedef struct packed {
        logic [2:0]   chan;
        wafe_sample_s sample;
    } wafe_mon_s;
endpackage
